//--- core/dup_core.sv
// two-channel uart with apb registers, vectored interrupt and output port
`timescale 1ns/1ps
`default_nettype none
module dup_core import dup_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_ack_in_n,
  output logic [7:0] vec_data_out,
  output logic vec_data_oe,
  output logic xfer_ack_n,
  output logic xfer_ack_oe,
  output logic irq_req_n,
  output logic irq_req_oe,
  input wire logic ser_in_a,
  input wire logic ser_in_b,
  output logic ser_out_a,
  output logic ser_out_b,
  output logic [7:0] out_port_pins,
  output logic [7:0] out_port_oe
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] first_mode_reg;
    logic [1:0][7:0] mode2;
    logic [1:0] mode_ptr;
    logic [1:0] rx_en;
    logic [1:0] tx_en;
    logic [1:0][7:0] hold;
    logic [1:0] hold_full;
    logic [1:0][7:0] rx_data;
    logic [1:0] rx_rdy;
    logic [1:0] ovr;
    logic [7:0] irq_mask_reg;
    logic [7:0] irq_state_reg;
    logic [7:0] vector_number_reg;
    logic [7:0] out_port_config_reg;
    logic [7:0] out_port_value_reg;
    logic [15:0] ct_pre;
    logic [15:0] ct_cnt;
    logic ct_run;
    logic ct_rdy;
    logic ct_out;
    logic [15:0] div_cnt;
    logic [15:0] div_val;
    logic test;
    logic [31:0] prdata;
    logic iack_act;
    logic [7:0] vec_q;
  } dup_core_s;
  dup_core_s s_reg, s_next;

  logic tick16;
  logic [1:0] tx_ready, tx_busy, tx_line, rx_done, loop, rx_in, ser_out;
  logic [1:0][7:0] rx_byte;
  logic [1:0] chan_sel;
  logic [7:0] ofs;
  logic setup, access, wr, pending, hit;

  function automatic logic is_local(input logic [7:0] m2);
    is_local = (m2[1:0] == CHMODE_LOCAL);
  endfunction

  // status byte: rx ready, tx ready, tx empty, overrun
  function automatic logic [7:0] chan_status(input dup_core_s s,
                                             input int c,
                                             input logic busy);
    chan_status = {3'h0, s.ovr[c], 1'b0, ~busy & ~s.hold_full[c] & s.tx_en[c],
                   ~s.hold_full[c] & s.tx_en[c], s.rx_rdy[c]};
  endfunction

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  assign rx_in[0] = ser_in_a;
  assign rx_in[1] = ser_in_b;
  assign ser_out_a = ser_out[0];
  assign ser_out_b = ser_out[1];

  for (genvar c = 0; c < 2; c++) begin : g_chan
    assign loop[c] = is_local(s_reg.mode2[c]);
    // loopback keeps the pin at mark and feeds the receiver internally
    assign ser_out[c] = loop[c] | tx_line[c];
    dup_tx u_tx (
      .sys_clk(sys_clk),
      .reset(reset),
      .tick16(tick16),
      .enable(s_reg.tx_en[c]),
      .load_valid(s_reg.hold_full[c]),
      .load_data(s_reg.hold[c]),
      .load_ready(tx_ready[c]),
      .line(tx_line[c]),
      .busy(tx_busy[c])
    );
    dup_rx u_rx (
      .sys_clk(sys_clk),
      .reset(reset),
      .tick16(tick16),
      .enable(s_reg.rx_en[c]),
      .ser_in(loop[c] ? tx_line[c] : rx_in[c]),
      .done(rx_done[c]),
      .data(rx_byte[c])
    );
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign chan_sel = {paddr >= CH_STRIDE && paddr < (CH_STRIDE << 1),
                     paddr < CH_STRIDE};
  assign ofs = paddr & (CH_STRIDE - 8'h01);
  // zero wait states: every access phase completes in its first cycle
  assign pready = 1'b1;
  assign prdata = s_reg.prdata;
  assign pslverr = access && !hit;
  assign pending = |(s_reg.irq_state_reg & s_reg.irq_mask_reg);
  assign tick16 = s_reg.test || (s_reg.div_cnt == 16'h0000);

  always_comb begin
    hit = 1'b0;
    if (|chan_sel) begin
      hit = (ofs == OFS_MODE) || (ofs == OFS_STAT) || (ofs == OFS_CMD)
            || (ofs == OFS_DATA);
    end else begin
      case (paddr)
        OFS_IMR, OFS_ISR, OFS_IVR, OFS_OUT_PORT_CONFIG_REG, OFS_OPSET, OFS_OPCLR,
        OFS_CTPRE, OFS_CTCMD, OFS_BAUD, OFS_TEST: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.div_cnt = (s_reg.div_cnt == 16'h0000) ? s_reg.div_val
                                                 : s_reg.div_cnt - 16'h0001;
    // read data is latched in setup so it comes from a flop in access
    if (setup) begin
      s_next.prdata = 32'h0000_0000;
      for (int c = 0; c < 2; c++) begin
        if (chan_sel[c]) begin
          case (ofs)
            OFS_MODE: s_next.prdata[7:0] = s_reg.mode_ptr[c]
                ? s_reg.mode2[c] : s_reg.first_mode_reg[c];
            OFS_STAT: s_next.prdata[7:0] = chan_status(s_reg, c,
                                                       tx_busy[c]);
            OFS_DATA: s_next.prdata[7:0] = s_reg.rx_data[c];
            default: s_next.prdata[7:0] = BYTE_ZERO;
          endcase
        end
      end
      case (paddr)
        OFS_IMR: s_next.prdata[7:0] = s_reg.irq_mask_reg;
        OFS_ISR: s_next.prdata[7:0] = s_reg.irq_state_reg;
        OFS_IVR: s_next.prdata[7:0] = s_reg.vector_number_reg;
        OFS_OUT_PORT_CONFIG_REG: s_next.prdata[7:0] = s_reg.out_port_config_reg;
        OFS_OPSET: s_next.prdata[7:0] = s_reg.out_port_value_reg;
        OFS_CTPRE: s_next.prdata[15:0] = s_reg.ct_pre;
        OFS_CTCMD: s_next.prdata[15:0] = s_reg.ct_cnt;
        OFS_BAUD: s_next.prdata[15:0] = s_reg.div_val;
        OFS_TEST: s_next.prdata[0] = s_reg.test;
        default: ;
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      if (tx_ready[c] && s_reg.hold_full[c]) begin
        s_next.hold_full[c] = 1'b0;
      end
      if (chan_sel[c] && access) begin
        if (wr && ofs == OFS_MODE) begin
          if (s_reg.mode_ptr[c]) begin
            s_next.mode2[c] = pwdata[7:0];
          end else begin
            s_next.first_mode_reg[c] = pwdata[7:0];
            s_next.mode_ptr[c] = 1'b1;
          end
        end
        if (wr && ofs == OFS_CMD) begin
          if (pwdata[CMD_RX_EN]) s_next.rx_en[c] = 1'b1;
          if (pwdata[CMD_RX_DIS]) s_next.rx_en[c] = 1'b0;
          if (pwdata[CMD_TX_EN]) s_next.tx_en[c] = 1'b1;
          if (pwdata[CMD_TX_DIS]) s_next.tx_en[c] = 1'b0;
          if (pwdata[CMD_PTR_RST]) s_next.mode_ptr[c] = 1'b0;
          if (pwdata[CMD_OVR_CLR]) s_next.ovr[c] = 1'b0;
        end
        // a write to a full holding register is dropped
        if (wr && ofs == OFS_DATA && s_reg.tx_en[c]
            && !s_reg.hold_full[c]) begin
          s_next.hold[c] = pwdata[7:0];
          s_next.hold_full[c] = 1'b1;
        end
        if (!pwrite && ofs == OFS_DATA) s_next.rx_rdy[c] = 1'b0;
      end
      // arrival after the read clear wins over it
      if (rx_done[c]) begin
        if (s_reg.rx_rdy[c] && !(access && !pwrite && chan_sel[c]
                                 && ofs == OFS_DATA)) begin
          s_next.ovr[c] = 1'b1;
        end else begin
          s_next.rx_data[c] = rx_byte[c];
        end
        s_next.rx_rdy[c] = 1'b1;
      end
    end
    if (wr) begin
      case (paddr)
        OFS_IMR: s_next.irq_mask_reg = pwdata[7:0];
        OFS_IVR: s_next.vector_number_reg = pwdata[7:0];
        OFS_OUT_PORT_CONFIG_REG: s_next.out_port_config_reg = pwdata[7:0];
        OFS_OPSET: s_next.out_port_value_reg =
            s_reg.out_port_value_reg | pwdata[7:0];
        OFS_OPCLR: s_next.out_port_value_reg =
            s_reg.out_port_value_reg & ~pwdata[7:0];
        OFS_CTPRE: s_next.ct_pre = pwdata[15:0];
        OFS_CTCMD: begin
          if (pwdata[CT_START]) begin
            s_next.ct_run = 1'b1;
            s_next.ct_cnt = s_reg.ct_pre;
          end
          if (pwdata[CT_STOP]) begin
            s_next.ct_run = 1'b0;
            s_next.ct_rdy = 1'b0;
          end
        end
        OFS_BAUD: s_next.div_val = pwdata[15:0];
        OFS_TEST: s_next.test = pwdata[0];
        default: ;
      endcase
    end
    // counter runs on the 16x baud tick; terminal count sets ready sticky
    if (s_reg.ct_run && tick16) begin
      if (s_reg.ct_cnt == 16'h0000) begin
        s_next.ct_cnt = s_reg.ct_pre;
        s_next.ct_rdy = 1'b1;
        s_next.ct_out = ~s_reg.ct_out;
      end else begin
        s_next.ct_cnt = s_reg.ct_cnt - 16'h0001;
      end
    end
    // request to send drops once channel a has nothing left to send
    if (s_reg.first_mode_reg[0][MR1_RTS_AUTO] && !tx_busy[0]
        && !s_reg.hold_full[0]) begin
      s_next.out_port_value_reg[OP_RTS] = 1'b0;
    end
    s_next.irq_state_reg = {2'b00, s_reg.rx_rdy[1],
                            ~s_reg.hold_full[1] & s_reg.tx_en[1],
                            s_reg.ct_rdy, 1'b0, s_reg.rx_rdy[0],
                            ~s_reg.hold_full[0] & s_reg.tx_en[0]};
    // iack answer is held until the host lifts its acknowledge
    if (irq_ack_in_n) begin
      s_next.iack_act = 1'b0;
    end else if (pending && !s_reg.iack_act) begin
      s_next.iack_act = 1'b1;
      s_next.vec_q = s_reg.vector_number_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.vector_number_reg <= VEC_RST;
      s_reg.ct_pre <= CT_RST;
      s_reg.div_val <= DIV_RST;
      s_reg.div_cnt <= DIV_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign xfer_ack_n = 1'b0;
  assign xfer_ack_oe = access || s_reg.iack_act;
  assign vec_data_out = s_reg.vec_q;
  assign vec_data_oe = s_reg.iack_act;
  assign irq_req_n = 1'b0;
  assign irq_req_oe = pending;

  always_comb begin
    out_port_pins = ~s_reg.out_port_value_reg;
    out_port_oe = 8'hff;
    if (s_reg.out_port_config_reg[OUT_PORT_CONFIG_REG_CT_SEL]) begin
      out_port_pins[OP_CT] = 1'b0;
      out_port_oe[OP_CT] = s_reg.ct_out;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence iack_req;
    !irq_ack_in_n && pending && !s_reg.iack_act;
  endsequence

  a_reset_clears: assert property (@(posedge sys_clk) $fell(reset) |->
    s_reg.irq_mask_reg == 8'h00 && s_reg.irq_state_reg == 8'h00
    && s_reg.out_port_config_reg == 8'h00 && s_reg.rx_rdy == 2'b00)
    else $error("registers not cleared by reset");
  a_reset_vector: assert property (@(posedge sys_clk) $fell(reset) |->
    s_reg.vector_number_reg == VEC_RST)
    else $error("vector not loaded by reset");
  a_reset_port_high: assert property (@(posedge sys_clk) $fell(reset) |->
    out_port_pins == 8'hff && !s_reg.ct_run)
    else $error("port not high or counter running after reset");
  a_reset_chan_idle: assert property (@(posedge sys_clk) $fell(reset) |->
    s_reg.tx_en == 2'b00 && ser_out == 2'b11 && !irq_req_oe)
    else $error("channel active after reset");
  a_reset_mode_ptr: assert property (@(posedge sys_clk) $fell(reset) |->
    s_reg.mode_ptr == 2'b00 && !s_reg.test)
    else $error("mode pointer or test mode not reset");
  a_bus_ack: assert property (@(posedge sys_clk) disable iff (reset)
    (psel && penable) |-> xfer_ack_oe && !xfer_ack_n && pready)
    else $error("no transfer acknowledge during access");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
    ($rose(s_reg.irq_state_reg[1]) && s_reg.irq_mask_reg[1])
    |-> irq_req_oe && !irq_req_n)
    else $error("enabled condition does not raise interrupt");
  a_irq_release: assert property (@(posedge sys_clk) disable iff (reset)
    ((s_reg.irq_state_reg & s_reg.irq_mask_reg) == 8'h00)
    |-> !irq_req_oe)
    else $error("interrupt held with no enabled condition");
  a_iack_vector: assert property (@(posedge sys_clk) disable iff (reset)
    iack_req |=> vec_data_oe && xfer_ack_oe
    && vec_data_out == $past(s_reg.vector_number_reg))
    else $error("iack not answered with vector");
  a_loop_mark: assert property (@(posedge sys_clk) disable iff (reset)
    loop[0] |-> ser_out_a)
    else $error("loopback channel not at mark");
  a_rts_auto: assert property (@(posedge sys_clk) disable iff (reset)
    (s_reg.first_mode_reg[0][MR1_RTS_AUTO] && !tx_busy[0]
     && !s_reg.hold_full[0] && !wr) |=> out_port_pins[OP_RTS])
    else $error("request to send not deasserted");
  a_ct_pin: assert property (@(posedge sys_clk) disable iff (reset)
    s_reg.out_port_config_reg[OUT_PORT_CONFIG_REG_CT_SEL]
    |-> out_port_oe[OP_CT] == s_reg.ct_out && !out_port_pins[OP_CT])
    else $error("counter output not open drain on bit 3");
endmodule // dup_core
`default_nettype wire

//--- core/dup_pkg.sv
// constants, register map and types shared by the dual uart block
package dup_pkg;
  // ----------------------------------------------------------------
  // clock and bit timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned DEF_BAUD = 9600;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [15:0] DIV_RST =
    16'((CLK_HZ / (DEF_BAUD * OVERSAMPLE)) - 1);
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ----------------------------------------------------------------
  // register map, byte offsets on apb
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_IMR = 8'h40;
  localparam logic [7:0] OFS_ISR = 8'h44;
  localparam logic [7:0] OFS_IVR = 8'h48;
  localparam logic [7:0] OFS_OUT_PORT_CONFIG_REG = 8'h4c;
  localparam logic [7:0] OFS_OPSET = 8'h50;
  localparam logic [7:0] OFS_OPCLR = 8'h54;
  localparam logic [7:0] OFS_CTPRE = 8'h58;
  localparam logic [7:0] OFS_CTCMD = 8'h5c;
  localparam logic [7:0] OFS_BAUD = 8'h60;
  localparam logic [7:0] OFS_TEST = 8'h64;
  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_RST = 8'h0f;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] CT_RST = 16'hffff;
  localparam int MR1_RTS_AUTO = 0;
  localparam logic [1:0] CHMODE_LOCAL = 2'h2;
  localparam int CMD_RX_EN = 0;
  localparam int CMD_RX_DIS = 1;
  localparam int CMD_TX_EN = 2;
  localparam int CMD_TX_DIS = 3;
  localparam int CMD_PTR_RST = 4;
  localparam int CMD_OVR_CLR = 5;
  localparam int CT_START = 0;
  localparam int CT_STOP = 1;
  localparam int OUT_PORT_CONFIG_REG_CT_SEL = 3;
  localparam int OP_RTS = 0;
  localparam int OP_CT = 3;

  typedef enum logic [3:0] {
    BIT_IDLE = 4'h1,
    BIT_START = 4'h2,
    BIT_DATA = 4'h4,
    BIT_STOP = 4'h8
  } dup_bit_e;
endpackage

//--- core/dup_tx.sv
// one transmitter: start bit, eight data bits lsb first, one stop bit
`timescale 1ns/1ps
`default_nettype none
module dup_tx import dup_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tick16,
  input wire logic enable,
  input wire logic load_valid,
  input wire logic [7:0] load_data,
  output logic load_ready,
  output logic line,
  output logic busy
);
  typedef struct packed {
    dup_bit_e st;
    logic [3:0] sub;
    logic [2:0] idx;
    logic [7:0] shreg;
    logic line;
  } dup_tx_s;
  dup_tx_s s_reg, s_next;

  assign load_ready = enable && (s_reg.st == BIT_IDLE);
  assign line = s_reg.line;
  assign busy = (s_reg.st != BIT_IDLE);

  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      BIT_IDLE: begin
        s_next.line = 1'b1;
        if (load_ready && load_valid) begin
          s_next.st = BIT_START;
          s_next.shreg = load_data;
          s_next.sub = 4'h0;
          s_next.line = 1'b0;
        end
      end
      BIT_START, BIT_DATA: begin
        if (tick16) begin
          s_next.sub = s_reg.sub + 4'h1;
          if (s_reg.sub == SUB_LAST) begin
            s_next.line = s_reg.shreg[0];
            s_next.shreg = {1'b1, s_reg.shreg[7:1]};
            if (s_reg.st == BIT_START) begin
              s_next.st = BIT_DATA;
              s_next.idx = 3'h0;
            end else if (s_reg.idx == BIT_LAST) begin
              s_next.st = BIT_STOP;
              s_next.line = 1'b1;
            end else begin
              s_next.idx = s_reg.idx + 3'h1;
            end
          end
        end
      end
      BIT_STOP: begin
        if (tick16) begin
          s_next.sub = s_reg.sub + 4'h1;
          if (s_reg.sub == SUB_LAST) begin
            s_next.st = BIT_IDLE;
          end
        end
      end
      default: s_next.st = BIT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '{st: BIT_IDLE, sub: 4'h0, idx: 3'h0, shreg: BYTE_ZERO,
                 line: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  a_tx_idle_mark: assert property (@(posedge sys_clk) disable iff (reset)
    s_reg.st == BIT_IDLE |-> line)
    else $error("tx line not at mark while idle");
  a_tx_lsb_first: assert property (@(posedge sys_clk) disable iff (reset)
    (s_reg.st == BIT_START && tick16 && s_reg.sub == SUB_LAST)
    |=> line == $past(s_reg.shreg[0]))
    else $error("first data bit is not the lsb");
endmodule // dup_tx
`default_nettype wire

//--- core/dup_rx.sv
// one receiver: 16x oversampled, false start rejected, lsb first
`timescale 1ns/1ps
`default_nettype none
module dup_rx import dup_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tick16,
  input wire logic enable,
  input wire logic ser_in,
  output logic done,
  output logic [7:0] data
);
  typedef struct packed {
    dup_bit_e st;
    logic [3:0] sub;
    logic [2:0] idx;
    logic [7:0] shreg;
    logic done;
  } dup_rx_s;
  dup_rx_s s_reg, s_next;

  assign done = s_reg.done;
  assign data = s_reg.shreg;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      BIT_IDLE: begin
        // low is space: a falling line starts a character
        if (enable && tick16 && !ser_in) begin
          s_next.st = BIT_START;
          s_next.sub = 4'h0;
        end
      end
      BIT_START: begin
        if (tick16) begin
          s_next.sub = s_reg.sub + 4'h1;
          if (s_reg.sub == SUB_MID) begin
            // a glitch back to mark is a false start
            s_next.st = ser_in ? BIT_IDLE : BIT_DATA;
            s_next.sub = 4'h0;
            s_next.idx = 3'h0;
          end
        end
      end
      BIT_DATA: begin
        if (tick16) begin
          s_next.sub = s_reg.sub + 4'h1;
          if (s_reg.sub == SUB_LAST) begin
            s_next.shreg = {ser_in, s_reg.shreg[7:1]};
            s_next.idx = s_reg.idx + 3'h1;
            if (s_reg.idx == BIT_LAST) begin
              s_next.st = BIT_STOP;
            end
          end
        end
      end
      BIT_STOP: begin
        if (tick16) begin
          s_next.sub = s_reg.sub + 4'h1;
          if (s_reg.sub == SUB_LAST) begin
            s_next.st = BIT_IDLE;
            s_next.done = 1'b1;
          end
        end
      end
      default: s_next.st = BIT_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '{st: BIT_IDLE, sub: 4'h0, idx: 3'h0, shreg: BYTE_ZERO,
                 done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  a_rx_lsb_first: assert property (@(posedge sys_clk) disable iff (reset)
    (s_reg.st == BIT_DATA && tick16 && s_reg.sub == SUB_LAST)
    |=> s_reg.shreg[7] == $past(ser_in))
    else $error("received bit not shifted in from the top");
endmodule // dup_rx
`default_nettype wire

//--- tb/dup_line_model.sv
// serial line partner: cable from tx back to rx, frame capture
`timescale 1ns/1ps
`default_nettype none
module dup_line_model (
  input wire logic sys_clk,
  input wire logic tx_line,
  output logic rx_line,
  output logic [7:0] last_byte
);
  // cable loopback, so the receiver sees mark while the line idles
  assign rx_line = tx_line;
  initial begin
    last_byte = 8'h00;
    forever begin
      @(negedge tx_line);
      // bit is 16 clocks in test mode; sample at mid bit
      repeat (24) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        last_byte[i] = tx_line;
        repeat (16) @(posedge sys_clk);
      end
    end
  end
endmodule // dup_line_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the dual uart core over apb
`timescale 1ns/1ps
`default_nettype none
module testbench import dup_pkg::*;;
  logic sys_clk, reset, psel, penable, pwrite, irq_ack_in_n, pready;
  logic pslverr, vec_data_oe, xfer_ack_oe, irq_req_oe, slv_err;
  logic xfer_ack_n, irq_req_n;
  logic ser_in_a, ser_in_b, ser_out_a, ser_out_b;
  logic [7:0] paddr, vec_data_out, out_port_pins, out_port_oe, byte_a;
  logic [31:0] pwdata, prdata, rd;
  int num_errors, num_checks;
  dup_core u_dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_ack_in_n, .vec_data_out,
    .vec_data_oe, .xfer_ack_n, .xfer_ack_oe, .irq_req_n, .irq_req_oe,
    .ser_in_a, .ser_in_b, .ser_out_a, .ser_out_b, .out_port_pins,
    .out_port_oe);
  dup_line_model u_line_a (.sys_clk, .tx_line(ser_out_a),
    .rx_line(ser_in_a), .last_byte(byte_a));
  dup_line_model u_line_b (.sys_clk, .tx_line(ser_out_b),
    .rx_line(ser_in_b), .last_byte());
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // idle cycle at the end keeps two requests from sharing one edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the watchdog ends a slave that never answers
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    slv_err = pslverr;
    chk(xfer_ack_oe, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chk_rst();
    xfer(0, OFS_IVR, 0, rd); chk(rd, VEC_RST);
    xfer(0, OFS_IMR, 0, rd); chk(rd, 0);
    xfer(0, OFS_OUT_PORT_CONFIG_REG, 0, rd); chk(rd, 0);
    xfer(0, OFS_OPSET, 0, rd); chk(rd, 0);
    xfer(0, OFS_STAT, 0, rd); chk(rd, 0);
    xfer(0, OFS_TEST, 0, rd); chk(rd, 0);
    // first write must land in the first mode register
    xfer(1, OFS_MODE, 32'h40, rd);
    xfer(1, OFS_CMD, 32'h10, rd);
    xfer(0, OFS_MODE, 0, rd); chk(rd, 32'h40);
    chk(out_port_pins, 8'hff);
    chk(out_port_oe, 8'hff);
    chk({ser_out_a, ser_out_b}, 2'h3);
    chk(irq_req_oe, 0);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end
  initial begin
    int n;
    logic o;
    {num_errors, num_checks, n} = 0;
    o = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    irq_ack_in_n = 1'b1;
    reset = 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk_rst();
    xfer(0, 8'h7c, 0, rd); chk(slv_err, 1);
    chk(rd, 0);
    xfer(1, OFS_TEST, 1, rd);
    xfer(1, OFS_CMD, 32'h5, rd);
    xfer(1, OFS_DATA, 32'ha5, rd);
    do begin
      xfer(0, OFS_STAT, 0, rd);
      n++;
    end while (rd[0] !== 1'b1 && n < 300);
    chk(byte_a, 8'ha5);
    xfer(1, OFS_IMR, 32'h2, rd);
    chk(irq_req_oe, 1);
    chk(irq_req_n, 0);
    irq_ack_in_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({vec_data_oe, xfer_ack_oe, vec_data_out}, {2'h3, VEC_RST});
    chk(xfer_ack_n, 0);
    irq_ack_in_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(vec_data_oe, 0);
    xfer(0, OFS_DATA, 0, rd); chk(rd, 32'ha5);
    // interrupt state register trails the ready flag by one clock
    @(posedge sys_clk);
    chk(irq_req_oe, 0);
    irq_ack_in_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(vec_data_oe, 0);
    irq_ack_in_n <= 1'b1;
    xfer(1, OFS_OPSET, 1, rd); chk(out_port_pins, 8'hfe);
    xfer(1, OFS_MODE, 1, rd);
    @(posedge sys_clk);
    chk(out_port_pins, 8'hff);
    // local loopback: frame goes to the receiver, pin stays at mark
    xfer(1, OFS_MODE, 32'h2, rd);
    xfer(1, OFS_DATA, 32'h3c, rd);
    n = 0;
    do begin
      xfer(0, OFS_STAT, 0, rd);
      n++;
    end while (rd[0] !== 1'b1 && n < 300);
    xfer(0, OFS_DATA, 0, rd); chk(rd, 32'h3c);
    chk(byte_a, 8'ha5);
    xfer(1, OFS_OUT_PORT_CONFIG_REG, 32'h8, rd); chk(out_port_pins[OP_CT], 0);
    xfer(1, OFS_CTPRE, 32'h2, rd);
    xfer(1, OFS_CTCMD, 32'h1, rd);
    // tick every clock in test mode: output flips every third clock
    o = out_port_oe[OP_CT];
    repeat (3) @(posedge sys_clk);
    chk(out_port_oe[OP_CT], !o);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk_rst();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
